// *** rtc_load_sync_barrier.sv ***
// Clock-set request routing and all-CPU shutdown barrier of one shared module
//
// Contract
// - Entry chip recodes to c6, checks validity, makes two-bit group pointer.
// - Valid command and pointer go to all four entry chips of the group.
// - Valid command's 64-bit operand is cut into four 16-bit slices.
// - Source id is 5 bits: 3 from entry chip, 2 from routing.
// - Two buffers per group; A first, B overflow, B moves up as A drains.
// - Groups arbitrate in rotating order 0..3; winner drops to lowest.
// - After a group wins, a stop blocks further clock-set requests locally and remotely.
// - Local winner alternates with remote request, local first; I/O skips this.
// - c6 reaches all distribution paths, broadcast as local and remote traffic.
// - Remote copy passes straight on so all 32 CPU-side chips see it.
// - On c6 a CPU-side chip latches it and suspends until the clock loads.
// - Every chip of a group sends a shutdown vote to its controller.
// - Controller with all group votes signals group completion to other controllers.
// - All four group completions give a module-completion vote to the other module.
// - Returned module vote makes controllers raise release strobe to all chips at once.
// - On release, partition chips forward c6 and operand to their processor.
// - After release each chip counts 10 clock periods, then resumes.
// - Designated chips send next-load permit, re-enabling clock-set acceptance.
// - Originator's chip returns c24 to the originating processor.
`timescale 1ns/1ps
`include "rtc_barrier_regs.svh"
module rtc_load_sync_barrier #(
  parameter int NUM_GROUPS = 4,
  parameter int CHIPS_PER_GROUP = 4,
  parameter logic MODULE_ID = 1'b0,
  parameter int PERMIT_CHIP = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input rtc_barrier_pkg::rtc_cpu_req_t [NUM_GROUPS-1:0] i_cpu_req,
  output logic [NUM_GROUPS-1:0] o_req_ready,
  input wire logic [NUM_GROUPS-1:0][1:0] i_group_partition,
  output logic o_stop_to_remote,
  input wire logic i_remote_stop,
  input rtc_barrier_pkg::rtc_msg_t i_remote_req,
  output logic o_remote_ack,
  output rtc_barrier_pkg::rtc_msg_t o_remote_copy,
  output logic o_module_vote,
  input wire logic i_module_vote,
  output rtc_barrier_pkg::rtc_cpu_out_t [NUM_GROUPS*CHIPS_PER_GROUP-1:0] o_cpu_out,
  output logic [NUM_GROUPS*CHIPS_PER_GROUP-1:0] o_cpu_hold,
  output logic [NUM_GROUPS-1:0] o_next_load_permit
);
  import rtc_barrier_pkg::*;

  localparam int NC = NUM_GROUPS * CHIPS_PER_GROUP;
  localparam int GW = (NUM_GROUPS > 1) ? $clog2(NUM_GROUPS) : 1;

  rtc_entry_t [NUM_GROUPS-1:0] ent;
  rtc_entry_t [NUM_GROUPS-1:0] buf_a;
  rtc_entry_t [NUM_GROUPS-1:0] buf_b;
  logic [NUM_GROUPS-1:0] a_v;
  logic [NUM_GROUPS-1:0] b_v;
  logic [NUM_GROUPS-1:0] arb_req;
  logic [NUM_GROUPS-1:0] grant;
  logic [GW-1:0] win_idx;
  logic take;
  logic stop_all;
  rtc_msg_t local_pend;
  logic busy;
  logic pref_local;
  logic grant_l;
  logic grant_r;
  rtc_msg_t bcast;
  rtc_msg_t held;
  rtc_phase_t phase;
  logic [NC-1:0] shut;
  logic [NUM_GROUPS-1:0] group_done;
  logic release_strobe;
  logic [3:0] resume_cnt;
  logic resume_done;

  // ****************************************
  // Entry stage and input buffers per group
  // ****************************************
  generate
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
      logic push;
      logic pop;

      rtc_entry_chip u_entry (
        .i_req(i_cpu_req[g]),
        .i_partition(i_group_partition[g]),
        .o_entry(ent[g])
      );

      // Refuse only when the overflow slot is taken
      assign o_req_ready[g] = !b_v[g];
      assign push = ent[g].valid && o_req_ready[g];
      assign pop = grant[g] && take;
      assign arb_req[g] = a_v[g] && !stop_all;

      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          a_v[g] <= 1'b0;
          b_v[g] <= 1'b0;
          buf_a[g] <= '0;
          buf_b[g] <= '0;
        end else if (i_clk_en) begin
          if (pop) begin
            if (b_v[g]) begin
              buf_a[g] <= buf_b[g];
              a_v[g] <= 1'b1;
              b_v[g] <= push;
              buf_b[g] <= ent[g];
            end else begin
              a_v[g] <= push;
              buf_a[g] <= ent[g];
            end
          end else if (push) begin
            if (!a_v[g]) begin
              buf_a[g] <= ent[g];
              a_v[g] <= 1'b1;
            end else begin
              buf_b[g] <= ent[g];
              b_v[g] <= 1'b1;
            end
          end
        end
      end

      buf_advance_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && pop && b_v[g]) |=> a_v[g] && buf_a[g] == $past(buf_b[g]))
        else $error("Buffer B did not move up into A");
    end
  endgenerate

  // ****************************************
  // Group arbitration and stop
  // ****************************************
  rtc_rotating_arbiter #(
    .N(NUM_GROUPS),
    .W(GW)
  ) u_arb (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_req(arb_req),
    .i_take(take),
    .o_grant(grant),
    .o_idx(win_idx)
  );

  // Any operation in flight anywhere holds off new winners
  assign stop_all = busy || local_pend.valid || i_remote_stop;
  assign take = |grant;
  assign o_stop_to_remote = busy || local_pend.valid;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      local_pend <= '0;
    end else if (i_clk_en) begin
      if (take) begin
        local_pend.valid <= 1'b1;
        local_pend.code <= buf_a[win_idx].code;
        local_pend.grp_ptr <= buf_a[win_idx].grp_ptr;
        local_pend.src_id <= {2'(win_idx), buf_a[win_idx].id_lo};
        local_pend.data <= buf_a[win_idx].slice;
      end else if (grant_l) begin
        local_pend.valid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Local against remote, then broadcast
  // ****************************************
  assign grant_l = !busy && local_pend.valid && (!i_remote_req.valid || pref_local);
  assign grant_r = !busy && i_remote_req.valid && !grant_l;
  assign o_remote_ack = grant_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pref_local <= 1'b1;
    end else if (i_clk_en && (grant_l || grant_r)) begin
      pref_local <= grant_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy <= 1'b0;
    end else if (i_clk_en) begin
      if (grant_l || grant_r) begin
        busy <= 1'b1;
      end else if (|o_next_load_permit) begin
        busy <= 1'b0;
      end
    end
  end

  // One pulse feeds every local path and the remote copy alike
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      bcast <= '0;
      held <= '0;
      o_remote_copy <= '0;
    end else if (i_clk_en) begin
      bcast.valid <= 1'b0;
      o_remote_copy.valid <= 1'b0;
      if (grant_l || grant_r) begin
        bcast <= grant_l ? local_pend : i_remote_req;
        bcast.code <= `RTC_CMD_BCAST;
        o_remote_copy <= grant_l ? local_pend : i_remote_req;
        o_remote_copy.code <= `RTC_CMD_BCAST;
      end
      if (bcast.valid && phase == PH_IDLE) begin
        held <= bcast;
      end
    end
  end

  // ****************************************
  // Barrier sequence
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      phase <= PH_IDLE;
    end else if (i_clk_en) begin
      unique case (phase)
        PH_IDLE: begin
          if (bcast.valid) begin
            phase <= PH_VOTE;
          end
        end
        PH_VOTE: begin
          if (release_strobe) begin
            phase <= PH_RESUME;
          end
        end
        PH_RESUME: begin
          if (resume_done) begin
            phase <= PH_IDLE;
          end
        end
      endcase
    end
  end

  // Controllers: group completion, then module completion
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      group_done <= '0;
      o_module_vote <= 1'b0;
      release_strobe <= 1'b0;
    end else if (i_clk_en) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        group_done[g] <= (phase == PH_VOTE)
                         && (&shut[g*CHIPS_PER_GROUP +: CHIPS_PER_GROUP]);
      end
      o_module_vote <= (phase == PH_VOTE) && (&group_done) && !release_strobe;
      release_strobe <= (phase == PH_VOTE) && o_module_vote && i_module_vote
                        && !release_strobe;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      resume_cnt <= '0;
    end else if (i_clk_en) begin
      if (release_strobe) begin
        resume_cnt <= `RTC_RESUME_CP;
      end else if (phase == PH_RESUME && resume_cnt != 4'h0) begin
        resume_cnt <= resume_cnt - 4'h1;
      end
    end
  end

  assign resume_done = (phase == PH_RESUME) && (resume_cnt == 4'h1);

  // ****************************************
  // CPU-side chips
  // ****************************************
  generate
    for (genvar c = 0; c < NC; c++) begin : g_chip
      localparam int GRP = c / CHIPS_PER_GROUP;
      localparam int IDX = c % CHIPS_PER_GROUP;
      logic originator;

      // Local chips hold the lower or upper half of each group's CPUs
      assign originator = (held.src_id == {2'(GRP), MODULE_ID, 2'(IDX)});

      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          shut[c] <= 1'b0;
        end else if (i_clk_en) begin
          if (bcast.valid && phase == PH_IDLE) begin
            shut[c] <= 1'b1;
          end else if (resume_done) begin
            shut[c] <= 1'b0;
          end
        end
      end

      assign o_cpu_hold[c] = shut[c];

      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          o_cpu_out[c] <= '0;
        end else if (i_clk_en) begin
          o_cpu_out[c].valid <= 1'b0;
          if (release_strobe && i_group_partition[GRP] == held.grp_ptr) begin
            o_cpu_out[c].valid <= 1'b1;
            o_cpu_out[c].code <= `RTC_CMD_BCAST;
            o_cpu_out[c].data <= held.data;
          end else if (resume_done && originator) begin
            o_cpu_out[c].valid <= 1'b1;
            o_cpu_out[c].code <= `RTC_CMD_SET;
            o_cpu_out[c].data <= '0;
          end
        end
      end

      if (IDX == PERMIT_CHIP) begin : g_permit
        always_ff @(posedge i_ref_clk) begin
          if (i_reset) begin
            o_next_load_permit[GRP] <= 1'b0;
          end else if (i_clk_en) begin
            o_next_load_permit[GRP] <= resume_done;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  entry_recode_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && take) |=> local_pend.code == `RTC_CMD_BCAST)
    else $error("Accepted request not recoded to broadcast code");

  slice_join_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && take) |=> local_pend.data == $past(buf_a[win_idx].slice))
    else $error("Operand slices did not rejoin in order");

  group_stop_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (local_pend.valid || busy) |-> grant == '0)
    else $error("Group granted while an operation is in flight");

  side_toggle_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && grant_l && i_remote_req.valid) |=> !pref_local)
    else $error("Local/remote priority did not alternate");

  copy_out_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    bcast.valid |-> o_remote_copy.valid && o_remote_copy.data == bcast.data)
    else $error("Remote copy missing for broadcast");

  all_shut_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && bcast.valid && phase == PH_IDLE) |=> &shut)
    else $error("Not every chip shut down on broadcast");

  module_vote_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_module_vote |-> &group_done)
    else $error("Module vote raised without every group");

  release_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    release_strobe |-> $past(o_module_vote && i_module_vote))
    else $error("Release strobe without both module votes");

  resume_count_a: assert property (@(posedge i_ref_clk)
    disable iff (i_reset || !i_clk_en)
    release_strobe |=> o_cpu_hold[0] [*8] ##1 o_cpu_hold[0] ##1 o_cpu_hold[0] ##1 !o_cpu_hold[0])
    else $error("Shutdown did not last ten clock periods");

  permit_free_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && |o_next_load_permit) |=> !busy)
    else $error("Permit did not re-enable acceptance");

  single_op_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (grant_l || grant_r) |-> !busy && phase == PH_IDLE)
    else $error("Second clock-set started while one is in progress");

  local_win_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) grant_l);
  remote_win_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) grant_r);
  full_cycle_c: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    release_strobe ##[1:20] (|o_next_load_permit));

endmodule : rtc_load_sync_barrier

// *** rtc_barrier_regs.svh ***
// Constants for the clock-set synchronisation barrier
`ifndef RTC_BARRIER_REGS_SVH
`define RTC_BARRIER_REGS_SVH

// Command codes
`define RTC_CMD_SET 8'h18
`define RTC_CMD_BCAST 8'h06

// Field layout
`define RTC_SLICE_W 16
`define RTC_SLICES 4
`define RTC_ID_LO_W 3
`define RTC_GRP_PTR_W 2

// Clock periods from release strobe to end of shutdown
`define RTC_RESUME_CP 4'hA

`endif

// *** rtc_barrier_pkg.sv ***
// Types shared by the clock-set barrier modules
package rtc_barrier_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [2:0] cpu;
    logic [63:0] operand;
  } rtc_cpu_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [1:0] grp_ptr;
    logic [2:0] id_lo;
    logic [3:0][15:0] slice;
  } rtc_entry_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [1:0] grp_ptr;
    logic [4:0] src_id;
    logic [63:0] data;
  } rtc_msg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [63:0] data;
  } rtc_cpu_out_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_VOTE,
    PH_RESUME
  } rtc_phase_t;

endpackage : rtc_barrier_pkg

// *** rtc_entry_chip.sv ***
// Entry stage: recode, check, group pointer and operand slicing
`timescale 1ns/1ps
`include "rtc_barrier_regs.svh"
module rtc_entry_chip (
  input rtc_barrier_pkg::rtc_cpu_req_t i_req,
  input logic [1:0] i_partition,
  output rtc_barrier_pkg::rtc_entry_t o_entry
);
  import rtc_barrier_pkg::*;

  // ****************************************
  // Recode and slice
  // ****************************************
  always_comb begin
    o_entry = '0;
    if (i_req.valid && i_req.code == `RTC_CMD_SET) begin
      o_entry.valid = 1'b1;
      o_entry.code = `RTC_CMD_BCAST;
      o_entry.grp_ptr = i_partition;
      o_entry.id_lo = i_req.cpu;
      for (int k = 0; k < `RTC_SLICES; k++) begin
        o_entry.slice[k] = i_req.operand[k*`RTC_SLICE_W +: `RTC_SLICE_W];
      end
    end
  end

endmodule : rtc_entry_chip

// *** rtc_rotating_arbiter.sv ***
// Rotating-priority arbiter across CPU groups
`timescale 1ns/1ps
module rtc_rotating_arbiter #(
  parameter int N = 4,
  parameter int W = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [N-1:0] i_req,
  input wire logic i_take,
  output logic [N-1:0] o_grant,
  output logic [W-1:0] o_idx
);
  logic [W-1:0] ptr;
  logic [W-1:0] cand;
  logic found;

  // ****************************************
  // Search from the current head
  // ****************************************
  always_comb begin
    o_grant = '0;
    o_idx = '0;
    found = 1'b0;
    cand = '0;
    for (int k = 0; k < N; k++) begin
      cand = W'((int'(ptr) + k) % N);
      if (!found && i_req[cand]) begin
        found = 1'b1;
        o_idx = cand;
        o_grant[cand] = 1'b1;
      end
    end
  end

  // Winner drops to the bottom, cyclic order kept
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ptr <= '0;
    end else if (i_clk_en && i_take && found) begin
      ptr <= (o_idx == W'(N - 1)) ? '0 : o_idx + 1'b1;
    end
  end

  rotate_head_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && i_take && found) |=>
      ptr == (($past(o_idx) == W'(N - 1)) ? '0 : $past(o_idx) + 1'b1))
    else $error("Arbiter head did not move past the winner");

endmodule : rtc_rotating_arbiter

// *** rtc_cpu_model.sv ***
// Far-side model: processor cores, remote module request and vote echo
`timescale 1ns/1ps
module rtc_cpu_model (
  input wire logic i_ref_clk,
  input wire logic i_clk_en,
  input wire logic [3:0] i_ready,
  input wire logic i_ack,
  input wire logic i_vote,
  output rtc_barrier_pkg::rtc_cpu_req_t [3:0] o_req,
  output rtc_barrier_pkg::rtc_msg_t o_rem,
  output logic o_vote
);
  import rtc_barrier_pkg::*;
  rtc_cpu_req_t q [4][$];
  rtc_msg_t rq [$];
  int vote_lag = 0;
  int lag = 0;
  logic [3:0] tk;
  logic rtk;

  initial begin
    o_req = '0;
    o_rem = '0;
    o_vote = 1'b0;
  end

  task automatic push(input int g, input rtc_cpu_req_t r);
    q[g].push_back(r);
  endtask : push

  task automatic push_rem(input rtc_msg_t m);
    rq.push_back(m);
  endtask : push_rem

  // ****************************************
  // Requests held until taken at an edge
  // ****************************************
  always @(posedge i_ref_clk) begin
    for (int g = 0; g < 4; g++) begin
      tk[g] = o_req[g].valid & i_ready[g] & i_clk_en;
    end
    rtk = o_rem.valid & i_ack & i_clk_en;
    #1;
    for (int g = 0; g < 4; g++) begin
      if (tk[g]) void'(q[g].pop_front());
      if (tk[g] || !o_req[g].valid) begin
        if (q[g].size() > 0) begin
          o_req[g] = q[g][0];
        end else begin
          // Released lines do not keep the last value
          o_req[g].valid = 1'b0;
          o_req[g].operand = ~o_req[g].operand;
        end
      end
    end
    if (rtk) void'(rq.pop_front());
    if (rtk || !o_rem.valid) begin
      if (rq.size() > 0) begin
        o_rem = rq[0];
      end else begin
        o_rem.valid = 1'b0;
        o_rem.data = ~o_rem.data;
      end
    end
    // Remote module answers the vote after a settable lag
    if (!i_vote) begin
      lag = 0;
      o_vote = 1'b0;
    end else if (lag >= vote_lag) begin
      o_vote = 1'b1;
    end else begin
      lag++;
    end
  end
endmodule : rtc_cpu_model

// *** tb.sv ***
// Self-checking bench for the clock-set barrier
`timescale 1ns/1ps
module tb;
  import rtc_barrier_pkg::*;
  logic i_ref_clk;
  logic i_reset;
  logic [3:0][1:0] part;
  logic rstop;
  rtc_cpu_req_t [3:0] req;
  rtc_msg_t rem;
  rtc_msg_t copy;
  rtc_cpu_out_t [15:0] cpu_out;
  logic [15:0] hold;
  logic [3:0] ready;
  logic [3:0] permit;
  logic ack;
  logic stop;
  logic mvote;
  logic rvote;
  logic clk_en;
  int n_errors = 0;
  int cmp_count = 0;
  int seed;
  logic [1:0] head;

  rtc_load_sync_barrier dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(clk_en),
    .i_cpu_req(req), .o_req_ready(ready), .i_group_partition(part),
    .o_stop_to_remote(stop), .i_remote_stop(rstop), .i_remote_req(rem),
    .o_remote_ack(ack), .o_remote_copy(copy), .o_module_vote(mvote),
    .i_module_vote(rvote), .o_cpu_out(cpu_out), .o_cpu_hold(hold),
    .o_next_load_permit(permit));
  rtc_cpu_model cpus (.i_ref_clk(i_ref_clk), .i_clk_en(clk_en), .i_ready(ready),
    .i_ack(ack), .i_vote(mvote), .o_req(req), .o_rem(rem), .o_vote(rvote));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // Ceiling well above the roughly 400 cycles the tests need
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_errors++;
    summarize();
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : check

  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask : tick

  function automatic logic [15:0] outs();
    for (int c = 0; c < 16; c++) outs[c] = cpu_out[c].valid;
  endfunction : outs

  // Next winner of the rotating arbiter from the head group
  function automatic logic [1:0] win(input logic [3:0] pend, input logic [1:0] h);
    win = h;
    for (int k = 3; k >= 0; k--) if (pend[2'(h + k)]) win = 2'(h + k);
  endfunction : win

  task automatic push_loc(input logic [1:0] g, input logic [7:0] cd, input logic [2:0] cpu,
      input logic [63:0] d);
    cpus.push(int'(g), rtc_cpu_req_t'{1'b1, cd, cpu, d});
  endtask : push_loc

  // Walks one operation from broadcast to resume, timed from the copy pulse
  task automatic follow(input logic [4:0] sid, input logic [1:0] gp, input logic [63:0] d);
    int n;
    int oc;
    n = 0;
    oc = int'(sid[4:3]) * 4 + int'(sid[1:0]);
    cpus.vote_lag = int'($unsigned($random(seed)) % 4);
    while (copy.valid !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    check("copy_code", copy.code, 8'h06);
    check("copy_src", copy.src_id, sid);
    check("copy_ptr", copy.grp_ptr, gp);
    check("copy_data", copy.data, d);
    tick();
    check("hold_all", hold, 16'hFFFF);
    check("stop_out", stop, 1'b1);
    tick();
    tick();
    check("mod_vote", mvote, 1'b1);
    n = 0;
    while (outs() === 16'h0 && n < 40) begin
      tick();
      n++;
    end
    for (int c = 0; c < 16; c++) begin
      check("out_valid", cpu_out[c].valid, part[c / 4] == gp);
      if (part[c / 4] == gp) begin
        check("out_code", cpu_out[c].code, 8'h06);
        check("out_data", cpu_out[c].data, d);
      end
    end
    repeat (9) begin
      tick();
      check("hold_on", hold, 16'hFFFF);
      check("one_op", copy.valid, 1'b0);
      check("no_ack", ack, 1'b0);
    end
    tick();
    check("hold_off", hold, 16'h0);
    check("permit", permit, 4'hF);
    if (sid[2] == 1'b0) begin
      check("ret_valid", cpu_out[oc].valid, 1'b1);
      check("ret_code", cpu_out[oc].code, 8'h18);
      check("ret_data", cpu_out[oc].data, 64'h0);
    end
    tick();
    check("permit_end", permit, 4'h0);
  endtask : follow

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [3:0] pend;
    logic [2:0] ca [4];
    logic [63:0] da [4];
    logic [1:0] g;
    logic seen;
    rtc_msg_t mz;
    seed = 32'hc7ea;
    i_reset = 1'b1;
    clk_en = 1'b1;
    rstop = 1'b0;
    head = 2'd0;
    for (int k = 0; k < 4; k++) part[k] = 2'($random(seed));
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_reset = 1'b0;
    check("ready_rst", ready, 4'hF);
    check("hold_rst", hold, 16'h0);
    check("vote_rst", mvote, 1'b0);
    $display("done reset");
    for (int i = 0; i < 4; i++) begin
      g = 2'($random(seed));
      ca[0] = 3'($random(seed));
      da[0] = {$random(seed), $random(seed)};
      push_loc(g, 8'h18, ca[0], da[0]);
      follow({g, ca[0]}, part[g], da[0]);
      head = g + 2'd1;
    end
    $display("done single");
    for (int k = 0; k < 4; k++) begin
      ca[k] = 3'($random(seed));
      da[k] = {$random(seed), $random(seed)};
      push_loc(2'(k), 8'h18, ca[k], da[k]);
    end
    pend = 4'hF;
    for (int k = 0; k < 4; k++) begin
      g = win(pend, head);
      follow({g, ca[g]}, part[g], da[g]);
      pend[g] = 1'b0;
      head = g + 2'd1;
    end
    $display("done rotate");
    // Remote stop keeps group 2 waiting, so both buffers fill
    rstop = 1'b1;
    for (int k = 0; k < 3; k++) begin
      ca[k] = 3'($random(seed));
      da[k] = {$random(seed), $random(seed)};
      push_loc(2'd2, 8'h18, ca[k], da[k]);
    end
    seen = 1'b0;
    repeat (20) begin
      tick();
      seen = seen | copy.valid;
    end
    check("stopped", seen, 1'b0);
    check("ready_b", ready, 4'b1011);
    rstop = 1'b0;
    for (int k = 0; k < 3; k++) follow({2'd2, ca[k]}, part[2], da[k]);
    head = 2'd3;
    $display("done buffers");
    push_loc(2'd1, 8'h05, 3'd0, {$random(seed), $random(seed)});
    seen = 1'b0;
    repeat (30) begin
      tick();
      seen = seen | copy.valid;
    end
    check("drop_code", seen, 1'b0);
    check("ready_drop", ready, 4'hF);
    $display("done invalid");
    // A frozen clock enable leaves a presented request untouched
    clk_en = 1'b0;
    ca[0] = 3'($random(seed));
    da[0] = {$random(seed), $random(seed)};
    push_loc(2'd3, 8'h18, ca[0], da[0]);
    seen = 1'b0;
    repeat (6) begin
      tick();
      seen = seen | copy.valid;
    end
    check("frozen_copy", seen, 1'b0);
    check("frozen_ready", ready, 4'hF);
    clk_en = 1'b1;
    follow({2'd3, ca[0]}, part[3], da[0]);
    head = 2'd0;
    $display("done freeze");
    // Local winner first, then the waiting remote beats a pending local
    ca[0] = 3'($random(seed));
    da[0] = {$random(seed), $random(seed)};
    push_loc(2'd0, 8'h18, ca[0], da[0]);
    repeat (3) tick();
    mz.valid = 1'b1;
    mz.code = 8'h06;
    mz.grp_ptr = part[0];
    mz.src_id = {2'($random(seed)), 1'b1, 2'($random(seed))};
    mz.data = {$random(seed), $random(seed)};
    cpus.push_rem(mz);
    ca[1] = 3'($random(seed));
    da[1] = {$random(seed), $random(seed)};
    push_loc(2'd1, 8'h18, ca[1], da[1]);
    follow({2'd0, ca[0]}, part[0], da[0]);
    follow(mz.src_id, mz.grp_ptr, mz.data);
    follow({2'd1, ca[1]}, part[1], da[1]);
    $display("done remote");
    summarize();
  end
endmodule : tb
